// [swncr_config_regs.sv]
// Configuration register bank of the switch node with its routing and debug logic.
`timescale 1ns/1ps
`default_nettype none
module swncr_config_regs #(
   parameter logic [7:0]        CHIP_ID      = 8'h5A, // Arbitrary value.
   parameter logic [7:0]        REVISION     = 8'h01, // Arbitrary value.
   parameter logic [7:0]        VERSION      = 8'h01, // Arbitrary value.
   parameter logic [7:0]        LINK_COUNT   = 8'h08,
   parameter logic [7:0]        CORE_COUNT   = 8'h01,
   parameter logic [7:0]        LINKS_PER_PE = 8'h04,
   // PLL defaults indexed by {boot_mode_pin1, boot_mode_pin0}.
   parameter logic [3:0][31:0]  PLL_BOOT     = {32'h0000_0000, 32'h0000_0000,
                                                32'h0000_0000, 32'h0000_0000},
   parameter int                DIV_W        = 16
) (
   input  wire logic                   i_clk_sys,
   input  wire logic                   i_rst_n,
   input  wire swncr_pkg::swncr_cfg_req_t i_cfg_req,
   output var  swncr_pkg::swncr_cfg_rsp_t o_cfg_rsp,
   input  wire logic                   i_boot_mode_pin0,
   input  wire logic                   i_boot_mode_pin1,
   input  wire logic [15:0]            i_route_dest,
   input  wire logic                   i_route_valid,
   output var  swncr_pkg::swncr_route_t o_route,
   output logic                        o_route_valid,
   output logic                        o_header_1byte,
   output logic [31:0]                 o_pll_settings,
   output logic                        o_tile_reset,
   output logic                        o_switch_clk_tick,
   output logic                        o_ref_clk_tick,
   input  wire logic                   i_debug_pin_n,
   output logic                        o_debug_pin_out,
   output logic                        o_debug_pin_oe_n,
   input  wire logic                   i_node_debug_mode,
   input  wire logic                   i_tile_debug_event,
   output logic                        o_debug_call_event
);

   ////////////////////////////////////////////////////////////////////////////
   // Register storage.

   logic [31:0] lock_r,   lock_nxt;
   logic [31:0] node_r,   node_nxt;
   logic [31:0] pll_r,    pll_nxt;
   logic [31:0] swdiv_r,  swdiv_nxt;
   logic [31:0] refdiv_r, refdiv_nxt;
   logic [31:0] dirlo_r,  dirlo_nxt;
   logic [31:0] dirhi_r,  dirhi_nxt;
   logic [31:0] dbgpin_r, dbgpin_nxt;
   logic [31:0] origin_r, origin_nxt;
   logic [1:0]  boot_r,   boot_nxt;
   logic        booted_r, booted_nxt;
   logic        treset_r, treset_nxt;

   logic        wr_req;
   logic        wr_ok;
   logic        pin_fall;
   logic        pin_call;
   logic        pin_prev_r;

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [31:0] mask);
      merge = (old_v & ~mask) | (new_v & mask);
   endfunction : merge

   function automatic logic hits(input logic [7:0] addr,
                                 input logic [7:0] ofs);
      hits = (addr == ofs);
   endfunction : hits

   assign wr_req   = i_cfg_req.valid && i_cfg_req.write;
   // Once the global lock is set only a reset can lift it again.
   assign wr_ok    = wr_req && !lock_r[swncr_pkg::BIT_WRITE_LOCK]; // see (RULE1)
   assign pin_fall = pin_prev_r && !i_debug_pin_n;
   assign pin_call = pin_fall && dbgpin_r[swncr_pkg::BIT_PIN_CALL_EN]; // see (RULE12)

   always_comb
   begin
      lock_nxt   = lock_r;
      node_nxt   = node_r;
      pll_nxt    = pll_r;
      swdiv_nxt  = swdiv_r;
      refdiv_nxt = refdiv_r;
      dirlo_nxt  = dirlo_r;
      dirhi_nxt  = dirhi_r;
      dbgpin_nxt = dbgpin_r;
      origin_nxt = origin_r;
      boot_nxt   = boot_r;
      booted_nxt = 1'b1;
      treset_nxt = 1'b0;
      // Mode pins are caught on the first edge after reset release.
      if (!booted_r)
      begin
         boot_nxt = {i_boot_mode_pin1, i_boot_mode_pin0};        // see (RULE16)
         pll_nxt  = PLL_BOOT[{i_boot_mode_pin1, i_boot_mode_pin0}]
                    & swncr_pkg::MASK_PLL;                       // see (RULE6)
      end
      if (wr_ok)
      begin
         unique case (i_cfg_req.addr)
            swncr_pkg::OFS_SWITCH_LOCK:
               lock_nxt = merge(lock_r, i_cfg_req.wdata,
                                swncr_pkg::MASK_SWITCH_LOCK);   // see (RULE3)
            swncr_pkg::OFS_NODE_ID:
               node_nxt = merge(node_r, i_cfg_req.wdata,
                                swncr_pkg::MASK_NODE_ID);       // see (RULE4)
            swncr_pkg::OFS_PLL:
               if (!lock_r[swncr_pkg::BIT_PLL_LOCK])            // see (RULE2)
               begin
                  pll_nxt    = merge(pll_r, i_cfg_req.wdata,
                                     swncr_pkg::MASK_PLL);      // see (RULE6)
                  treset_nxt = 1'b1;                            // see (RULE5)
               end
            swncr_pkg::OFS_SWITCH_DIV:
               swdiv_nxt = merge(swdiv_r, i_cfg_req.wdata,
                                 swncr_pkg::MASK_DIV);          // see (RULE7)
            swncr_pkg::OFS_REF_DIV:
               refdiv_nxt = merge(refdiv_r, i_cfg_req.wdata,
                                  swncr_pkg::MASK_DIV);         // see (RULE8)
            swncr_pkg::OFS_DIR_LOW:
               dirlo_nxt = merge(dirlo_r, i_cfg_req.wdata,
                                 swncr_pkg::MASK_DIR);          // see (RULE10)
            swncr_pkg::OFS_DIR_HIGH:
               dirhi_nxt = merge(dirhi_r, i_cfg_req.wdata,
                                 swncr_pkg::MASK_DIR);          // see (RULE11)
            swncr_pkg::OFS_DEBUG_PIN:
               dbgpin_nxt = merge(dbgpin_r, i_cfg_req.wdata,
                                  swncr_pkg::MASK_DEBUG_PIN);
            swncr_pkg::OFS_DEBUG_ORIGIN:
               origin_nxt = merge(origin_r, i_cfg_req.wdata,
                                  swncr_pkg::MASK_DEBUG_ORIGIN); // see (RULE15)
            default:
            begin
            end
         endcase
      end
      // Hardware events win over a software write in the same cycle and
      // replace the previous origin, so only the sources of the latest event stay set.
      if (pin_call || i_tile_debug_event)
      begin
         origin_nxt = '0;
         origin_nxt[swncr_pkg::BIT_ORIGIN_PIN]  = pin_call;           // see (RULE14)
         origin_nxt[swncr_pkg::BIT_ORIGIN_TILE] = i_tile_debug_event; // see (RULE15)
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         lock_r   <= swncr_pkg::RST_SWITCH_LOCK;
         node_r   <= swncr_pkg::RST_NODE_ID;
         pll_r    <= '0;
         swdiv_r  <= swncr_pkg::RST_SWITCH_DIV;
         refdiv_r <= swncr_pkg::RST_REF_DIV;
         dirlo_r  <= swncr_pkg::RST_DIR;
         dirhi_r  <= swncr_pkg::RST_DIR;
         dbgpin_r <= swncr_pkg::RST_DEBUG_PIN;
         origin_r <= swncr_pkg::RST_DEBUG_ORIGIN;
         boot_r   <= '0;
         booted_r <= 1'b0;
         treset_r <= 1'b0;
      end
      else
      begin
         lock_r   <= lock_nxt;
         node_r   <= node_nxt;
         pll_r    <= pll_nxt;
         swdiv_r  <= swdiv_nxt;
         refdiv_r <= refdiv_nxt;
         dirlo_r  <= dirlo_nxt;
         dirhi_r  <= dirhi_nxt;
         dbgpin_r <= dbgpin_nxt;
         origin_r <= origin_nxt;
         boot_r   <= boot_nxt;
         booted_r <= booted_nxt;
         treset_r <= treset_nxt;
      end
   end

   assign o_header_1byte = lock_r[swncr_pkg::BIT_HEADER_MODE]; // see (RULE3)
   assign o_pll_settings = pll_r;
   assign o_tile_reset   = treset_r;

   ////////////////////////////////////////////////////////////////////////////
   // Configuration read and response.

   swncr_pkg::swncr_cfg_rsp_t rsp_r, rsp_nxt;

   always_comb
   begin
      rsp_nxt       = '0;
      rsp_nxt.ack   = i_cfg_req.valid;
      // A locked write is acknowledged but marked, and changes nothing.
      rsp_nxt.denied = wr_req && (lock_r[swncr_pkg::BIT_WRITE_LOCK] ||
                       (hits(i_cfg_req.addr, swncr_pkg::OFS_PLL) &&
                        lock_r[swncr_pkg::BIT_PLL_LOCK]));      // see (RULE19)
      unique case (i_cfg_req.addr)
         swncr_pkg::OFS_DEVICE_ID:
         begin
            rsp_nxt.rdata = {CHIP_ID, 6'h00, boot_r, REVISION, VERSION};
            rsp_nxt.err   = i_cfg_req.write;
         end
         swncr_pkg::OFS_SWITCH_DESC:
         begin
            rsp_nxt.rdata = {8'h00, LINK_COUNT, CORE_COUNT, LINKS_PER_PE};
            rsp_nxt.err   = i_cfg_req.write;
         end
         swncr_pkg::OFS_SWITCH_LOCK:   rsp_nxt.rdata = lock_r;
         swncr_pkg::OFS_NODE_ID:       rsp_nxt.rdata = node_r;
         swncr_pkg::OFS_PLL:           rsp_nxt.rdata = pll_r;
         swncr_pkg::OFS_SWITCH_DIV:    rsp_nxt.rdata = swdiv_r;
         swncr_pkg::OFS_REF_DIV:       rsp_nxt.rdata = refdiv_r;
         swncr_pkg::OFS_DIR_LOW:       rsp_nxt.rdata = dirlo_r;
         swncr_pkg::OFS_DIR_HIGH:      rsp_nxt.rdata = dirhi_r;
         swncr_pkg::OFS_DEBUG_PIN:     rsp_nxt.rdata = dbgpin_r;
         swncr_pkg::OFS_DEBUG_ORIGIN:  rsp_nxt.rdata = origin_r;
         default:                      rsp_nxt.err   = 1'b1;
      endcase
      if (!i_cfg_req.valid)
      begin
         rsp_nxt = '0;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rsp_r <= '0;
      end
      else
      begin
         rsp_r <= rsp_nxt;
      end
   end

   assign o_cfg_rsp = rsp_r;

   ////////////////////////////////////////////////////////////////////////////
   // Clock dividers, expressed as one-cycle ticks of the PLL-rate clock.

   logic [1:0][DIV_W-1:0] div_cnt_r;
   logic [1:0][DIV_W-1:0] div_cnt_nxt;
   logic [1:0]            tick_r;
   logic [1:0]            tick_nxt;
   logic [1:0][DIV_W-1:0] div_limit;

   assign div_limit[0] = swdiv_r[DIV_W-1:0];  // see (RULE7)
   assign div_limit[1] = refdiv_r[DIV_W-1:0]; // see (RULE8)

   generate
      for (genvar g = 0; g < 2; g++)
      begin : g_div
         always_comb
         begin
            // Dividing by limit plus one; a lowered limit restarts cleanly.
            if (div_cnt_r[g] >= div_limit[g])
            begin
               div_cnt_nxt[g] = '0;
               tick_nxt[g]    = 1'b1;
            end
            else
            begin
               div_cnt_nxt[g] = div_cnt_r[g] + 1'b1;
               tick_nxt[g]    = 1'b0;
            end
         end

         always_ff @(posedge i_clk_sys or negedge i_rst_n)
         begin
            if (!i_rst_n)
            begin
               div_cnt_r[g] <= '0;
               tick_r[g]    <= 1'b0;
            end
            else
            begin
               div_cnt_r[g] <= div_cnt_nxt[g];
               tick_r[g]    <= tick_nxt[g];
            end
         end
      end
   endgenerate

   assign o_switch_clk_tick = tick_r[0];
   assign o_ref_clk_tick    = tick_r[1];

   ////////////////////////////////////////////////////////////////////////////
   // Routing decision.

   swncr_pkg::swncr_route_t route_now;
   swncr_pkg::swncr_route_t route_r, route_nxt;
   logic                    rvalid_r, rvalid_nxt;

   swncr_route_lookup #(
      .NODE_W (swncr_pkg::NODE_W),
      .DIR_W  (swncr_pkg::DIR_W)
   ) u_lookup (
      .i_node_id   (node_r[15:0]),
      .i_dest      (i_route_dest),
      .i_dir_table ({dirhi_r, dirlo_r}), // see (RULE10) (RULE11)
      .o_route     (route_now)
   );

   always_comb
   begin
      route_nxt  = i_route_valid ? route_now : route_r; // see (RULE9)
      rvalid_nxt = i_route_valid;
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         route_r  <= '0;
         rvalid_r <= 1'b0;
      end
      else
      begin
         route_r  <= route_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   assign o_route       = route_r;
   assign o_route_valid = rvalid_r;

   ////////////////////////////////////////////////////////////////////////////
   // Debug pin handling.

   logic call_r, call_nxt;
   logic pull_r, pull_nxt;

   always_comb
   begin
      call_nxt = pin_call;                                         // see (RULE12)
      pull_nxt = i_node_debug_mode &&
                 dbgpin_r[swncr_pkg::BIT_PIN_PULL_EN];             // see (RULE13)
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         call_r     <= 1'b0;
         pull_r     <= 1'b0;
         pin_prev_r <= 1'b1;
      end
      else
      begin
         call_r     <= call_nxt;
         pull_r     <= pull_nxt;
         pin_prev_r <= i_debug_pin_n;
      end
   end

   // Open drain: only ever drive low, enable is active low.
   assign o_debug_call_event = call_r;
   assign o_debug_pin_out    = 1'b0;
   assign o_debug_pin_oe_n   = !pull_r;

endmodule : swncr_config_regs
`default_nettype wire

// [swncr_pkg.sv]
// Package with the register map, field layout and carriers of the switch node.
//
// Overview of operation
// (RULE1) Global write lock bit 31 set rejects every configuration register write.
// (RULE2) Lock bit 8 set blocks any update of the PLL settings register.
// (RULE3) Bit 0 picks one-byte headers; every node must hold the same value.
// (RULE4) Writable 16-bit node identifier, reset zero, compared MSB first for routing.
// (RULE5) Any accepted write to the PLL settings register resets the tile.
// (RULE6) PLL fields: output divider 25:23, multiplier 20:8, input divider 6:0; MASK_PLL also keeps bit 21 writable.
// (RULE7) Switch clock is PLL clock divided by 16-bit field plus one, reset 0.
// (RULE8) Reference clock is PLL clock divided by its field plus one, reset 3.
// (RULE9) Mismatching destination routes by entry of most significant mismatching bit.
// (RULE10) Low table: eight 4-bit entries for bits 0 to 7, reset zero.
// (RULE11) High table: eight 4-bit entries for bits 8 to 15, reset zero.
// (RULE12) Debug pin control bit 1 lets the debug pin raise a debug call.
// (RULE13) Debug pin control bit 0 pulls the debug wire low in debug mode.
// (RULE14) Origin bit 4 set when the debug pin caused the latest debug event.
// (RULE15) Origin bit 0 set when the tile caused it; software may write it.
// (RULE16) Boot mode pins sampled at reset, shown in bits 23:16, pick PLL defaults.
// (RULE17) Requester uses node configuration reads and writes, not memory accesses.
// (RULE18) Destination equal to node identifier in all 16 bits is delivered locally.
// (RULE19) A write blocked by a lock leaves the register unchanged, no side effect.
package swncr_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int NODE_W = 16;
   localparam int DIR_W  = 4;

   // Register numbers as carried by the configuration request.
   localparam logic [7:0] OFS_DEVICE_ID    = 8'h00;
   localparam logic [7:0] OFS_SWITCH_DESC  = 8'h01;
   localparam logic [7:0] OFS_SWITCH_LOCK  = 8'h04;
   localparam logic [7:0] OFS_NODE_ID      = 8'h05;
   localparam logic [7:0] OFS_PLL          = 8'h06;
   localparam logic [7:0] OFS_SWITCH_DIV   = 8'h07;
   localparam logic [7:0] OFS_REF_DIV      = 8'h08;
   localparam logic [7:0] OFS_DIR_LOW      = 8'h0C;
   localparam logic [7:0] OFS_DIR_HIGH     = 8'h0D;
   localparam logic [7:0] OFS_DEBUG_PIN    = 8'h10;
   localparam logic [7:0] OFS_DEBUG_ORIGIN = 8'h1F;

   // Field positions.
   localparam int BIT_WRITE_LOCK   = 31;
   localparam int BIT_PLL_LOCK     = 8;
   localparam int BIT_HEADER_MODE  = 0;
   localparam int BIT_PIN_CALL_EN  = 1;
   localparam int BIT_PIN_PULL_EN  = 0;
   localparam int BIT_ORIGIN_PIN   = 4;
   localparam int BIT_ORIGIN_TILE  = 0;
   localparam int POS_BOOT_MODE    = 16;
   localparam int POS_CHIP_ID      = 24;
   localparam int POS_REVISION     = 8;
   localparam int POS_LINK_COUNT   = 16;
   localparam int POS_CORE_COUNT   = 8;

   // Writable bits of each register; all others read as zero.
   localparam logic [31:0] MASK_SWITCH_LOCK  = 32'h8000_0101;
   localparam logic [31:0] MASK_NODE_ID      = 32'h0000_FFFF;
   localparam logic [31:0] MASK_PLL          = 32'h03BF_FF7F;
   localparam logic [31:0] MASK_DIV          = 32'h0000_FFFF;
   localparam logic [31:0] MASK_DIR          = 32'hFFFF_FFFF;
   localparam logic [31:0] MASK_DEBUG_PIN    = 32'h0000_0003;
   localparam logic [31:0] MASK_DEBUG_ORIGIN = 32'h0000_0011;

   // Reset values.
   localparam logic [31:0] RST_SWITCH_LOCK  = 32'h0000_0000;
   localparam logic [31:0] RST_NODE_ID      = 32'h0000_0000;
   localparam logic [31:0] RST_SWITCH_DIV   = 32'h0000_0000;
   localparam logic [31:0] RST_REF_DIV      = 32'h0000_0003;
   localparam logic [31:0] RST_DIR          = 32'h0000_0000;
   localparam logic [31:0] RST_DEBUG_PIN    = 32'h0000_0000;
   localparam logic [31:0] RST_DEBUG_ORIGIN = 32'h0000_0000;

   typedef struct packed {
      logic              valid;
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } swncr_cfg_req_t;

   typedef struct packed {
      logic              ack;
      logic              err;
      logic              denied;
      logic [DATA_W-1:0] rdata;
   } swncr_cfg_rsp_t;

   typedef struct packed {
      logic             local_hit;
      logic [DIR_W-1:0] dir;
   } swncr_route_t;

endpackage : swncr_pkg

// [swncr_route_lookup.sv]
// Direction lookup from the most significant mismatching node bit.
`timescale 1ns/1ps
`default_nettype none
module swncr_route_lookup #(
   parameter int NODE_W = 16,
   parameter int DIR_W  = 4
) (
   input  wire logic [NODE_W-1:0]          i_node_id,
   input  wire logic [NODE_W-1:0]          i_dest,
   input  wire logic [NODE_W*DIR_W-1:0]    i_dir_table,
   output var  swncr_pkg::swncr_route_t    o_route
);

   logic [NODE_W-1:0] diff;

   always_comb
   begin
      diff              = i_node_id ^ i_dest;
      o_route.local_hit = (diff == '0);                 // see (RULE18)
      o_route.dir       = '0;
      // Ascending scan lets the highest mismatching bit win.
      for (int n = 0; n < NODE_W; n++)
      begin
         if (diff[n])
         begin
            o_route.dir = i_dir_table[n*DIR_W +: DIR_W]; // see (RULE9)
         end
      end
   end

endmodule : swncr_route_lookup
`default_nettype wire

// [swncr_config_regs_monitor.sv]
// Checker of the switch node register bank, watching its ports.
`timescale 1ns/1ps
`default_nettype none
module swncr_cfg_monitor (
   input wire logic                      i_clk_sys,
   input wire logic                      i_rst_n,
   input wire swncr_pkg::swncr_cfg_req_t i_cfg_req,
   input wire swncr_pkg::swncr_cfg_rsp_t o_cfg_rsp,
   input wire logic                      i_route_valid,
   input wire logic                      o_route_valid,
   input wire logic                      o_header_1byte,
   input wire logic [31:0]               o_pll_settings,
   input wire logic                      o_tile_reset,
   input wire logic                      i_debug_pin_n,
   input wire logic                      o_debug_pin_out,
   input wire logic                      o_debug_pin_oe_n,
   input wire logic                      i_node_debug_mode,
   input wire logic                      o_debug_call_event
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   logic pll_wr;
   logic lock_wr;
   assign pll_wr  = i_cfg_req.valid && i_cfg_req.write
                    && i_cfg_req.addr == swncr_pkg::OFS_PLL;
   assign lock_wr = i_cfg_req.valid && i_cfg_req.write
                    && i_cfg_req.addr == swncr_pkg::OFS_SWITCH_LOCK;
   ////////////////////////////////////////////////////////////
   chk_ack_next: assert property (i_cfg_req.valid |=> o_cfg_rsp.ack)
      else $error("request not answered");
   chk_ack_cause: assert property (o_cfg_rsp.ack |-> $past(i_cfg_req.valid))
      else $error("answer without request");
   chk_reset_cause: assert property (!pll_wr |=> !o_tile_reset)
      else $error("tile reset without PLL write");
   // The boot value lands on the first edge after reset, so skip it.
   chk_pll_stable: assert property ($past(i_rst_n) && !pll_wr |=> $stable(o_pll_settings))
      else $error("PLL changed without write");
   chk_denied_quiet: assert property (o_cfg_rsp.denied |-> !o_tile_reset
      && $stable(o_pll_settings) && $stable(o_header_1byte))
      else $error("refused write had an effect");
   chk_header_hold: assert property (!lock_wr |=> $stable(o_header_1byte))
      else $error("header mode changed unasked");
   chk_route_next: assert property (i_route_valid |=> o_route_valid)
      else $error("route result missing");
   chk_pull_cause: assert property (!o_debug_pin_oe_n |-> $past(i_node_debug_mode))
      else $error("debug wire pulled outside debug mode");
   chk_pull_level: assert property (o_debug_pin_out == 1'b0)
      else $error("debug wire driven high");
   chk_call_cause: assert property (o_debug_call_event |->
      !$past(i_debug_pin_n) || !$past(i_debug_pin_n, 2))
      else $error("debug call without pin activity");
endmodule : swncr_cfg_monitor
bind swncr_config_regs swncr_cfg_monitor u_mon (
   .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_cfg_req(i_cfg_req),
   .o_cfg_rsp(o_cfg_rsp), .i_route_valid(i_route_valid),
   .o_route_valid(o_route_valid), .o_header_1byte(o_header_1byte),
   .o_pll_settings(o_pll_settings), .o_tile_reset(o_tile_reset),
   .i_debug_pin_n(i_debug_pin_n), .o_debug_pin_out(o_debug_pin_out),
   .o_debug_pin_oe_n(o_debug_pin_oe_n),
   .i_node_debug_mode(i_node_debug_mode),
   .o_debug_call_event(o_debug_call_event));
`default_nettype wire

// [swncr_cfg_requester.sv]
// Model of the configuration requester on the far side of the bank.
`timescale 1ns/1ps
`default_nettype none
module swncr_cfg_requester (
   input  wire logic                      i_clk_sys,
   input  wire swncr_pkg::swncr_cfg_rsp_t i_cfg_rsp,
   output var  swncr_pkg::swncr_cfg_req_t o_cfg_req
);
   initial o_cfg_req = '0;
   // One word per transaction; after the taking edge the fields are
   // inverted so a design that samples them late sees garbage.
   task automatic xfer(input logic wr, input logic [7:0] a,
                       input logic [31:0] d,
                       output swncr_pkg::swncr_cfg_rsp_t r);
      int k;
      @(negedge i_clk_sys);
      o_cfg_req = '{valid: 1'b1, write: wr, addr: a, wdata: d};
      @(negedge i_clk_sys);
      o_cfg_req = '{valid: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
      r = i_cfg_rsp;
      for (k = 0; k < 3 && r.ack !== 1'b1; k++)
      begin
         @(negedge i_clk_sys);
         r = i_cfg_rsp;
      end
   endtask : xfer
endmodule : swncr_cfg_requester
`default_nettype wire

// [test_switch_node_config_regs.sv]
// Self-checking testbench of the switch node register bank.
`timescale 1ns/1ps
`default_nettype none
module test_switch_node_config_regs;
   localparam logic [3:0][31:0] BOOT = {32'h0000_0000, 32'h0000_0000,
                                        32'h0180_1203, 32'h0000_0000};
   logic                      clk = 1'b0;
   logic                      rst_n = 1'b0;
   swncr_pkg::swncr_cfg_req_t req;
   swncr_pkg::swncr_cfg_rsp_t rsp;
   swncr_pkg::swncr_cfg_rsp_t r;
   swncr_pkg::swncr_route_t   route;
   logic [15:0]               dest = 16'h0000;
   logic                      rvalid = 1'b0;
   logic                      pin_low = 1'b0;
   logic                      dbg_mode = 1'b0;
   logic                      tile_ev = 1'b0;
   logic                      route_vld, hdr, trst, stick, rtick;
   logic                      pin_out, oe_n, call_ev;
   logic [31:0]               pll;
   wire                       dbg_wire_n = (!oe_n || pin_low) ? 1'b0 : 1'b1;
   int                        n_fail = 0;
   int                        n_checks = 0;
   int                        n;
   always #20 clk = ~clk;
   swncr_cfg_requester u_req (.i_clk_sys(clk), .i_cfg_rsp(rsp),
                              .o_cfg_req(req));
   swncr_config_regs #(.PLL_BOOT(BOOT)) u_dut (
      .i_clk_sys(clk), .i_rst_n(rst_n), .i_cfg_req(req), .o_cfg_rsp(rsp),
      .i_boot_mode_pin0(1'b1), .i_boot_mode_pin1(1'b0),
      .i_route_dest(dest), .i_route_valid(rvalid), .o_route(route),
      .o_route_valid(route_vld), .o_header_1byte(hdr),
      .o_pll_settings(pll), .o_tile_reset(trst),
      .o_switch_clk_tick(stick), .o_ref_clk_tick(rtick),
      .i_debug_pin_n(dbg_wire_n), .o_debug_pin_out(pin_out),
      .o_debug_pin_oe_n(oe_n), .i_node_debug_mode(dbg_mode),
      .i_tile_debug_event(tile_ev), .o_debug_call_event(call_ev));
   ////////////////////////////////////////////////////////////
   task automatic stop_test();
      if (n_fail == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : stop_test
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic cfg(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      u_req.xfer(wr, a, d, r);
      check({31'h0, r.ack}, 32'h0000_0001);
      if (r.ack !== 1'b1)
         stop_test();
   endtask : cfg
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      cfg(1'b0, a, 32'h0000_0000);
      check(r.rdata, e);
   endtask : rd
   task automatic route_chk(input logic [15:0] d, input logic [4:0] e);
      int k;
      @(negedge clk);
      dest = d;
      rvalid = 1'b1;
      @(negedge clk);
      rvalid = 1'b0;
      dest = ~d;
      for (k = 0; k < 3 && route_vld !== 1'b1; k++)
         @(negedge clk);
      // Direction is meaningless on a local hit, so it is masked.
      check({27'h0, route.local_hit, route.local_hit ? 4'h0 : route.dir},
            {27'h0, e});
      if (route_vld !== 1'b1)
         stop_test();
   endtask : route_chk
   task automatic tick_chk(input int cyc, input int es, input int er);
      int s, t, k;
      s = 0;
      t = 0;
      for (k = 0; k < cyc; k++)
      begin
         @(negedge clk);
         s += stick;
         t += rtick;
      end
      check(32'(s), 32'(es));
      check(32'(t), 32'(er));
   endtask : tick_chk
   task automatic see_call(input logic e);
      int k;
      logic hit;
      hit = 1'b0;
      for (k = 0; k < 4; k++)
      begin
         @(negedge clk);
         hit = hit | call_ev;
      end
      check({31'h0, hit}, {31'h0, e});
   endtask : see_call
   ////////////////////////////////////////////////////////////
   initial
   begin
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      rd(8'h04, 32'h0000_0000);
      rd(8'h05, 32'h0000_0000);
      rd(8'h07, 32'h0000_0000);
      rd(8'h08, 32'h0000_0003);
      rd(8'h0C, 32'h0000_0000);
      rd(8'h0D, 32'h0000_0000);
      rd(8'h10, 32'h0000_0000);
      check(pll, BOOT[1]);
      cfg(1'b0, 8'h00, 32'h0000_0000);
      check({24'h0, r.rdata[23:16]}, 32'h0000_0001);
      cfg(1'b0, 8'h02, 32'h0000_0000);
      check({31'h0, r.err}, 32'h0000_0001);
      tick_chk(8, 8, 2);
      cfg(1'b1, 8'h07, 32'hFFFF_0002);
      tick_chk(12, 4, 3);
      cfg(1'b1, 8'h05, 32'hFFFF_ABCD);
      rd(8'h05, 32'h0000_ABCD);
      cfg(1'b1, 8'h0C, 32'h7654_3210);
      cfg(1'b1, 8'h0D, 32'hFEDC_BA98);
      rd(8'h0C, 32'h7654_3210);
      rd(8'h0D, 32'hFEDC_BA98);
      // Lower bits flip too, so only the top mismatch may decide.
      for (n = 0; n < 16; n++)
         route_chk(16'hABCD ^ 16'((32'h2 << n) - 1), {1'b0, 4'(n)});
      route_chk(16'hABCD, 5'h10);
      cfg(1'b1, 8'h06, 32'hFFFF_FFFF);
      check({31'h0, trst}, 32'h0000_0001);
      rd(8'h06, swncr_pkg::MASK_PLL);
      cfg(1'b1, 8'h10, 32'h0000_0002);
      pin_low = 1'b1;
      see_call(1'b1);
      pin_low = 1'b0;
      rd(8'h1F, 32'h0000_0010);
      tile_ev = 1'b1;
      @(negedge clk);
      tile_ev = 1'b0;
      rd(8'h1F, 32'h0000_0001);
      cfg(1'b1, 8'h1F, 32'h0000_0000);
      rd(8'h1F, 32'h0000_0000);
      cfg(1'b1, 8'h10, 32'h0000_0001);
      pin_low = 1'b1;
      see_call(1'b0);
      pin_low = 1'b0;
      dbg_mode = 1'b1;
      repeat (2) @(negedge clk);
      check({31'h0, oe_n}, 32'h0000_0000);
      dbg_mode = 1'b0;
      repeat (2) @(negedge clk);
      check({31'h0, oe_n}, 32'h0000_0001);
      cfg(1'b1, 8'h04, 32'h0000_0001);
      check({31'h0, hdr}, 32'h0000_0001);
      cfg(1'b1, 8'h04, 32'h0000_0101);
      cfg(1'b1, 8'h06, 32'h0000_0000);
      check({30'h0, r.denied, trst}, 32'h0000_0002);
      check(pll, swncr_pkg::MASK_PLL);
      cfg(1'b1, 8'h04, 32'h8000_0101);
      cfg(1'b1, 8'h05, 32'h0000_1234);
      check({31'h0, r.denied}, 32'h0000_0001);
      rd(8'h05, 32'h0000_ABCD);
      rd(8'h04, 32'h8000_0101);
      stop_test();
   end
endmodule : test_switch_node_config_regs
`default_nettype wire
